// [dac_link_if.sv]
// Carrier between the shift-clock logic and the system-clock core.
// Assumes word and bit count are quiet while the frame select is high.
`timescale 1ns/1ps
interface dac_link_if;
	logic [dac_pkg::WORD_W-1:0] word;
	logic [dac_pkg::BITS_W-1:0] bits;
	logic serial_out_chain;

	modport link (output word, output bits, output serial_out_chain);
	modport core (input word, input bits, input serial_out_chain);
endinterface : dac_link_if

// [dac_pkg.sv]
// Shared constants for the quad DAC serial front end.
// Assumes one system clock domain plus the serial shift clock domain.
package dac_pkg;

	// ======================================================================
	// Serial frame layout
	localparam int CH_COUNT = 4;
	localparam int WORD_W = 16;
	localparam int CODE_W = 12;
	localparam int BITS_W = 5;
	localparam logic [4:0] FIRST_BIT = 5'h01;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] BITS_MAX = 5'h1F;
	localparam int CH_SEL_LSB = 14;
	localparam int CH_SEL_W = 2;
	localparam int REFSEL_POS = 13;

	// ======================================================================
	// Pin synchroniser lanes and their values after reset
	localparam int PIN_W = 5;
	localparam int PIN_SYNC = 0;
	localparam int PIN_ZERO = 1;
	localparam int PIN_LOAD = 2;
	localparam int PIN_PD = 3;
	localparam int PIN_CHAIN = 4;
	localparam logic [4:0] PIN_RST = 5'h1F;

	// ======================================================================
	// Register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] DAC_BASE = 8'h10;
	localparam logic [7:0] IN_BASE = 8'h20;
	localparam logic [7:0] REG_STRIDE = 8'h04;

	// ======================================================================
	// Register fields
	localparam int CTRL_LOAD_POS = 0;
	localparam int CTRL_ZERO_POS = 1;
	localparam int STAT_PD_POS = 0;
	localparam int STAT_CHAIN_POS = 1;
	localparam int STAT_ABORT_POS = 2;
	localparam int STAT_INBUF_POS = 3;
	localparam int STAT_PEND_LSB = 4;
	localparam int STAT_FRAMES_LSB = 8;
	localparam int FRAMES_W = 8;

	// ======================================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dac_pkg

// [dac_serial_link.sv]
// Shift-clock side of the serial write port: shift register, bit count, chain out.
// Assumes frame select meets setup to the shift clock and the clock idles between frames.
`timescale 1ns/1ps
module dac_serial_link (
	input wire logic sclk_i,
	input wire logic sdin_i,
	input wire logic sync_n_i,
	dac_link_if.link lnk
);

	typedef struct packed {
		logic [dac_pkg::WORD_W-1:0] shreg;
		logic [dac_pkg::BITS_W-1:0] bits;
	} link_s;

	link_s state_q;
	link_s state_d;
	logic in_frame_q;
	logic sdo_q;

	// ======================================================================
	// Capture on falling edges, only while the frame is open
	always_comb
	begin
		state_d = state_q;
		if (!sync_n_i)
		begin
			state_d.shreg = {state_q.shreg[dac_pkg::WORD_W-2:0], sdin_i}; // see RULE7
			if (!in_frame_q)
			begin
				state_d.bits = dac_pkg::FIRST_BIT; // see RULE8
			end
			else if (state_q.bits != dac_pkg::BITS_MAX)
			begin
				state_d.bits = state_q.bits + dac_pkg::FIRST_BIT; // see RULE10
			end
		end
	end

	// No reset: the count is restarted by the first edge of every frame
	always_ff @(negedge sclk_i)
	begin
		state_q <= state_d;
	end

	// Marks that a frame edge has been seen; frame select high closes it
	always_ff @(negedge sclk_i or posedge sync_n_i)
	begin
		if (sync_n_i)
			in_frame_q <= 1'b0;
		else
			in_frame_q <= 1'b1;
	end

	// Chain output moves on rising edges, stable for the next falling edge
	always_ff @(posedge sclk_i)
	begin
		sdo_q <= state_q.shreg[dac_pkg::WORD_W-1]; // see RULE12 see RULE13
	end

	assign lnk.word = state_q.shreg;
	assign lnk.bits = state_q.bits;
	assign lnk.serial_out_chain = sdo_q;

	// ======================================================================
	// Checks on the shift-clock side
	AST_SHIFT_IN: assert property (@(negedge sclk_i) disable iff (sync_n_i) // see RULE7
		in_frame_q |=> state_q.shreg[0] == $past(sdin_i))
		else $error("Serial bit not captured on falling edge");
	AST_FIRST_BIT: assert property (@(negedge sclk_i) disable iff (sync_n_i) // see RULE10
		!in_frame_q |=> state_q.bits == dac_pkg::FIRST_BIT)
		else $error("Bit count did not restart at frame start");
	AST_SDO_FOLLOW: assert property (@(negedge sclk_i) disable iff (sync_n_i) // see RULE12
		in_frame_q |-> sdo_q == state_q.shreg[dac_pkg::WORD_W-1])
		else $error("Chain output not the outgoing bit");
	COV_FULL_FRAME: cover property (@(negedge sclk_i) state_q.bits == dac_pkg::FRAME_BITS);

endmodule : dac_serial_link

// [dac_serial_master.sv]
// Model of the serial master that writes frames into the DAC front end.
// Assumes the bench calls send_frame once at a time; clock idles high between frames.
`timescale 1ns/1ps
module dac_serial_master (
	output logic SCLK_O,
	output logic SDIN_O,
	output logic SYNC_N_O,
	input wire logic SDO_I
);
	// ==========================================================
	// Link timing: 80 ns period, well under the rate ceiling
	localparam realtime HALF = 40.0;

	// Idle levels; frame select rises once so the link's unreset frame marker starts clear
	initial
	begin
		SCLK_O = 1'b1;
		SYNC_N_O = 1'b0;
		SDIN_O = 1'b0;
		#1;
		SYNC_N_O = 1'b1; // A bare level at time zero may give no edge, leaving the marker unknown
	end

	// ==========================================================
	// One frame of n bits, MSB first; chain output taken on each fall
	task automatic send_frame(input logic [31:0] w, input int n, output logic [15:0] rb);
		rb = 16'h0000;
		#21.3; // Odd offset keeps the two clocks out of phase
		SYNC_N_O = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			SDIN_O = w[i];
			#(HALF);
			SCLK_O = 1'b0;
			rb = {rb[14:0], SDO_I};
			#(HALF);
			SCLK_O = 1'b1;
		end
		#5;
		SYNC_N_O = 1'b1;
		SDIN_O = ~SDIN_O; // Released line shows the inverse, not a stale value
		#100; // Frame select high time with the clock quiet
	endtask : send_frame
endmodule : dac_serial_master

// [quad_dac_serial_input_control.sv]
// Digital front end of a quad DAC: serial write port, input and DAC registers,
// control pins and an AXI4-Lite register view.
// Assumes MCLK_I at 250 MHz, SCLK_I from the serial master, idle between frames.
//
// What this block does
// RULE1 - Zero pin low clears every input and DAC register.
// RULE2 - Load pin low copies input registers holding new data into DAC registers.
// RULE3 - Master may pulse load pin or hold it low permanently.
// RULE4 - Each channel's reference buffering follows the select bit of its word.
// RULE5 - Board drives chain enable high in a chain, low standalone.
// RULE6 - Power-down pin low puts all four outputs into power-down, high impedance.
// RULE7 - Sixteen-bit shift register captures serial data on falling shift clock edges.
// RULE8 - Frame select falling powers up input buffers and enables the shift register.
// RULE9 - Input buffers power down again after every write cycle.
// RULE10 - A frame is the next sixteen falling edges after frame select falls.
// RULE11 - Frame select rising before the sixteenth edge aborts and discards the write.
// RULE12 - Shift register contents go out on chain output on rising edges.
// RULE13 - Downstream party samples chain output on the falling shift clock edge.
// RULE14 - Master keeps the shift clock at or below 30 MHz.
// RULE15 - With load held low each valid frame passes straight to the DAC register.
// RULE16 - Standalone, a frame latches on frame select rising after exactly sixteen bits.
`timescale 1ns/1ps
module quad_dac_serial_input_control #(
	parameter int CODE_W = dac_pkg::CODE_W
) (
	input wire logic MCLK_I,
	input wire logic SRST_I,
	input wire logic SCLK_I,
	input wire logic SDIN_I,
	input wire logic SYNC_N_I,
	input wire logic ZERO_ALL_N_I,
	input wire logic LOAD_OUTPUTS_N_I,
	input wire logic POWER_DOWN_N_I,
	input wire logic CHAIN_ENABLE_I,
	output logic SDO_O,
	output logic [dac_pkg::CH_COUNT*CODE_W-1:0] DAC_CODE_O,
	output logic [dac_pkg::CH_COUNT-1:0] REF_BUF_O,
	output logic PWRDN_O,
	output logic INBUF_EN_O,
	input wire logic [dac_pkg::ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [dac_pkg::ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I
);

	localparam int NCH = dac_pkg::CH_COUNT;

	typedef struct packed {
		logic [dac_pkg::PIN_W-1:0] pin_s1;
		logic [dac_pkg::PIN_W-1:0] pin_s2;
		logic sync_s3;
		logic [NCH-1:0][CODE_W-1:0] in_code;
		logic [NCH-1:0][CODE_W-1:0] dac_code;
		logic [NCH-1:0] in_ref;
		logic [NCH-1:0] dac_ref;
		logic [NCH-1:0] pending;
		logic inbuf_en;
		logic pwrdn;
		logic abort;
		logic [dac_pkg::FRAMES_W-1:0] frames;
		logic sw_load;
		logic sw_zero;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} core_s;

	core_s state_q;
	core_s state_d;

	logic sync_rise;
	logic chain_mode;
	logic frame_ok;
	logic [dac_pkg::CH_SEL_W-1:0] ch_sel;
	logic load_req;
	logic zero_req;
	logic wr_go;
	logic rd_go;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_word;

	// ======================================================================
	// Shift-clock domain
	dac_link_if lnk ();

	dac_serial_link u_link (
		.sclk_i(SCLK_I),
		.sdin_i(SDIN_I),
		.sync_n_i(SYNC_N_I),
		.lnk(lnk.link)
	);

	// ======================================================================
	// Frame qualification, read after the synchronised frame select rises.
	// The link words are static then because the shift clock idles.
	assign sync_rise = state_q.pin_s2[dac_pkg::PIN_SYNC] & ~state_q.sync_s3;
	assign chain_mode = state_q.pin_s2[dac_pkg::PIN_CHAIN]; // see RULE5
	assign frame_ok = chain_mode ? (lnk.bits >= dac_pkg::FRAME_BITS) // see RULE11
		: (lnk.bits == dac_pkg::FRAME_BITS); // see RULE16
	assign ch_sel = lnk.word[dac_pkg::CH_SEL_LSB +: dac_pkg::CH_SEL_W];
	// Load is level sensitive, so a held-low pin behaves as a stream of pulses
	assign load_req = ~state_q.pin_s2[dac_pkg::PIN_LOAD] | state_q.sw_load; // see RULE3
	assign zero_req = ~state_q.pin_s2[dac_pkg::PIN_ZERO] | state_q.sw_zero;

	// Bus handshakes, one write and one read outstanding
	assign wr_go = AWVALID_I & WVALID_I & ~state_q.bvalid;
	assign rd_go = ARVALID_I & ~state_q.rvalid;
	assign AWREADY_O = wr_go;
	assign WREADY_O = wr_go;
	assign ARREADY_O = rd_go;

	// ======================================================================
	// Next-state logic for the whole core
	always_comb
	begin
		state_d = state_q;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rd_word = 32'h0000_0000;

		// Two flops on each of the five control pins before use
		state_d.pin_s1[dac_pkg::PIN_SYNC] = SYNC_N_I;
		state_d.pin_s1[dac_pkg::PIN_ZERO] = ZERO_ALL_N_I;
		state_d.pin_s1[dac_pkg::PIN_LOAD] = LOAD_OUTPUTS_N_I;
		state_d.pin_s1[dac_pkg::PIN_PD] = POWER_DOWN_N_I;
		state_d.pin_s1[dac_pkg::PIN_CHAIN] = CHAIN_ENABLE_I;
		state_d.pin_s2 = state_q.pin_s1;
		state_d.sync_s3 = state_q.pin_s2[dac_pkg::PIN_SYNC];

		// Input buffers live only between frame select fall and rise
		state_d.inbuf_en = ~state_q.pin_s2[dac_pkg::PIN_SYNC]; // see RULE8 see RULE9
		state_d.pwrdn = ~state_q.pin_s2[dac_pkg::PIN_PD]; // see RULE6
		state_d.sw_load = 1'b0;
		state_d.sw_zero = 1'b0;

		// Transfer first, so a frame landing this cycle stays pending
		for (int i = 0; i < NCH; i++)
		begin
			if (load_req && state_q.pending[i])
			begin
				state_d.dac_code[i] = state_q.in_code[i]; // see RULE2 see RULE15
				state_d.dac_ref[i] = state_q.in_ref[i]; // see RULE4
				state_d.pending[i] = 1'b0;
			end
		end

		// Accept a complete frame into its channel's input register
		if (sync_rise && frame_ok)
		begin
			state_d.in_code[ch_sel] = lnk.word[CODE_W-1:0]; // see RULE10
			state_d.in_ref[ch_sel] = lnk.word[dac_pkg::REFSEL_POS]; // see RULE4
			state_d.pending[ch_sel] = 1'b1;
			state_d.frames = state_q.frames + 8'h01;
		end

		// Register writes
		if (wr_go)
		begin
			state_d.bvalid = 1'b1;
			if (AWADDR_I == dac_pkg::CTRL_OFS)
			begin
				wr_hit = 1'b1;
				state_d.sw_load = WDATA_I[dac_pkg::CTRL_LOAD_POS] & WSTRB_I[0];
				state_d.sw_zero = WDATA_I[dac_pkg::CTRL_ZERO_POS] & WSTRB_I[0];
			end
			else if (AWADDR_I == dac_pkg::STAT_OFS)
			begin
				wr_hit = 1'b1;
				if (WDATA_I[dac_pkg::STAT_ABORT_POS] && WSTRB_I[0])
				begin
					state_d.abort = 1'b0;
				end
			end
			for (int i = 0; i < NCH; i++)
			begin
				if (AWADDR_I == dac_pkg::DAC_BASE + 8'(i * 4)
					|| AWADDR_I == dac_pkg::IN_BASE + 8'(i * 4))
				begin
					wr_hit = 1'b1;
				end
			end
			state_d.bresp = wr_hit ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
		end
		else if (state_q.bvalid && BREADY_I)
		begin
			state_d.bvalid = 1'b0;
		end

		// Abort flag set after its clear so a same-cycle event is kept
		if (sync_rise && !frame_ok)
		begin
			state_d.abort = 1'b1; // see RULE11
		end

		// Clear dominates every other update of the input and DAC registers
		if (zero_req)
		begin
			state_d.in_code = '0; // see RULE1
			state_d.dac_code = '0;
			state_d.in_ref = '0;
			state_d.dac_ref = '0;
			state_d.pending = '0;
		end

		// Register reads
		if (ARADDR_I == dac_pkg::CTRL_OFS)
		begin
			rd_hit = 1'b1;
		end
		else if (ARADDR_I == dac_pkg::STAT_OFS)
		begin
			rd_hit = 1'b1;
			rd_word[dac_pkg::STAT_PD_POS] = state_q.pwrdn;
			rd_word[dac_pkg::STAT_CHAIN_POS] = chain_mode;
			rd_word[dac_pkg::STAT_ABORT_POS] = state_q.abort;
			rd_word[dac_pkg::STAT_INBUF_POS] = state_q.inbuf_en;
			rd_word[dac_pkg::STAT_PEND_LSB +: NCH] = state_q.pending;
			rd_word[dac_pkg::STAT_FRAMES_LSB +: dac_pkg::FRAMES_W] = state_q.frames;
		end
		for (int i = 0; i < NCH; i++)
		begin
			if (ARADDR_I == dac_pkg::DAC_BASE + 8'(i * 4))
			begin
				rd_hit = 1'b1;
				rd_word[CODE_W-1:0] = state_q.dac_code[i];
				rd_word[dac_pkg::REFSEL_POS] = state_q.dac_ref[i];
			end
			if (ARADDR_I == dac_pkg::IN_BASE + 8'(i * 4))
			begin
				rd_hit = 1'b1;
				rd_word[CODE_W-1:0] = state_q.in_code[i];
				rd_word[dac_pkg::REFSEL_POS] = state_q.in_ref[i];
			end
		end
		if (rd_go)
		begin
			state_d.rvalid = 1'b1;
			state_d.rdata = rd_word;
			state_d.rresp = rd_hit ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
		end
		else if (state_q.rvalid && RREADY_I)
		begin
			state_d.rvalid = 1'b0;
		end
	end

	// Synchronous reset; all pin lanes start high, the inactive level of the active-low pins and chain mode for chain enable
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
		begin
			state_q <= '0;
			state_q.pin_s1 <= dac_pkg::PIN_RST;
			state_q.pin_s2 <= dac_pkg::PIN_RST;
			state_q.sync_s3 <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ======================================================================
	// Remaining outputs, all from flops; the ready outputs above are combinational
	assign DAC_CODE_O = state_q.dac_code;
	assign REF_BUF_O = state_q.dac_ref;
	assign PWRDN_O = state_q.pwrdn;
	assign INBUF_EN_O = state_q.inbuf_en;
	assign SDO_O = lnk.serial_out_chain;
	assign BVALID_O = state_q.bvalid;
	assign BRESP_O = state_q.bresp;
	assign RVALID_O = state_q.rvalid;
	assign RDATA_O = state_q.rdata;
	assign RRESP_O = state_q.rresp;

	// ======================================================================
	// Checks on the system-clock side
	default clocking core_cb @(posedge MCLK_I);
	endclocking
	default disable iff (SRST_I);

	AST_ZERO_ALL: assert property ( // see RULE1
		!state_q.pin_s2[dac_pkg::PIN_ZERO] |=> state_q.dac_code == '0 && state_q.in_code == '0)
		else $error("Zero pin did not clear registers");
	AST_LOAD_COPY: assert property ( // see RULE2
		(!state_q.pin_s2[dac_pkg::PIN_LOAD] && state_q.pending[0] && !zero_req)
		|=> state_q.dac_code[0] == $past(state_q.in_code[0]))
		else $error("Load pin did not copy pending channel");
	AST_HOLD_DAC: assert property ( // see RULE3
		(state_q.pin_s2[dac_pkg::PIN_LOAD] && !state_q.sw_load && !zero_req)
		|=> $stable(state_q.dac_code))
		else $error("DAC register moved without load");
	AST_PASS_THROUGH: assert property ( // see RULE15
		(sync_rise && frame_ok && ch_sel == 2'h0 && !zero_req)
		##1 (load_req && !zero_req)
		|=> state_q.dac_code[0] == $past(lnk.word[CODE_W-1:0], 2))
		else $error("Frame did not pass to DAC register");
	AST_REF_SEL: assert property ( // see RULE4
		(sync_rise && frame_ok && ch_sel == 2'h0 && !zero_req)
		##1 (load_req && !zero_req)
		|=> REF_BUF_O[0] == $past(lnk.word[dac_pkg::REFSEL_POS], 2))
		else $error("Reference select not applied");
	AST_ABORT: assert property ( // see RULE11
		(sync_rise && lnk.bits < dac_pkg::FRAME_BITS && !zero_req)
		|=> state_q.abort && $stable(state_q.in_code) && $stable(state_q.frames))
		else $error("Short frame was not discarded");
	AST_EXACT_FRAME: assert property ( // see RULE16
		(sync_rise && !chain_mode && lnk.bits == dac_pkg::FRAME_BITS)
		|=> state_q.frames == $past(state_q.frames) + 8'h01)
		else $error("Sixteen-bit frame not latched");
	AST_INBUF: assert property ( // see RULE8
		$fell(state_q.pin_s2[dac_pkg::PIN_SYNC]) |=> INBUF_EN_O [*2])
		else $error("Input buffers not powered at frame start");
	AST_INBUF_OFF: assert property ( // see RULE9
		$rose(state_q.pin_s2[dac_pkg::PIN_SYNC]) |=> !INBUF_EN_O)
		else $error("Input buffers not powered down after write");
	AST_PWRDN: assert property ( // see RULE6
		!state_q.pin_s2[dac_pkg::PIN_PD] ##1 !state_q.pin_s2[dac_pkg::PIN_PD] |-> PWRDN_O)
		else $error("Power-down not applied");
	AST_BRESP: assert property (
		wr_go |=> BVALID_O && (BRESP_O == dac_pkg::RESP_OKAY) == $past(wr_hit))
		else $error("Write response missing or wrong");

	COV_FRAME: cover property (sync_rise && frame_ok);
	COV_ABORT: cover property (sync_rise && !frame_ok);
	COV_LOAD: cover property (load_req && state_q.pending != '0);

endmodule : quad_dac_serial_input_control

// [quad_dac_serial_input_control_tb.sv]
// Self-checking bench for the quad DAC serial front end.
// Assumes dac_serial_master drives the serial port; bus tasks speak AXI4-Lite.
`timescale 1ns/1ps
module quad_dac_serial_input_control_tb;
	// ==========================================================
	// Stimulus and observed signals
	logic MCLK_I, SRST_I, SCLK_I, SDIN_I, SYNC_N_I, SDO_O, PWRDN_O, INBUF_EN_O;
	logic ZERO_ALL_N_I, LOAD_OUTPUTS_N_I, POWER_DOWN_N_I, CHAIN_ENABLE_I;
	logic [47:0] DAC_CODE_O;
	logic [3:0] REF_BUF_O, WSTRB_I;
	logic [7:0] AWADDR_I, ARADDR_I;
	logic [31:0] WDATA_I, RDATA_O;
	logic [1:0] BRESP_O, RRESP_O, resp;
	logic AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
	logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
	logic [15:0] rb;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	quad_dac_serial_input_control DUT (.MCLK_I, .SRST_I, .SCLK_I, .SDIN_I, .SYNC_N_I,
		.ZERO_ALL_N_I, .LOAD_OUTPUTS_N_I, .POWER_DOWN_N_I, .CHAIN_ENABLE_I, .SDO_O,
		.DAC_CODE_O, .REF_BUF_O, .PWRDN_O, .INBUF_EN_O, .AWADDR_I, .AWVALID_I, .AWREADY_O,
		.WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I,
		.ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I);
	dac_serial_master host (.SCLK_O(SCLK_I), .SDIN_O(SDIN_I), .SYNC_N_O(SYNC_N_I), .SDO_I(SDO_O));

	// ==========================================================
	// Clock, and a cycle ceiling that cuts a hang short
	initial
	begin
		MCLK_I = 1'b0;
		forever #2 MCLK_I = ~MCLK_I;
	end
	always @(posedge MCLK_I)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			bad_count++;
			finish_test();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wait_clk(input int n);
		repeat (n) @(posedge MCLK_I);
	endtask : wait_clk

	// Address and data offered together; each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge MCLK_I);
		AWADDR_I <= a;
		WDATA_I <= d;
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		BREADY_I <= 1'b1;
		do
		begin
			@(posedge MCLK_I);
			if (AWVALID_I && AWREADY_O === 1'b1)
				AWVALID_I <= 1'b0;
			if (WVALID_I && WREADY_O === 1'b1)
				WVALID_I <= 1'b0;
		end
		while (BVALID_O !== 1'b1);
		resp = BRESP_O;
		BREADY_I <= 1'b0;
		check({30'h0, resp}, {30'h0, er}, "write response");
	endtask : axi_write

	// Read one word and compare data and response
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge MCLK_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		RREADY_I <= 1'b1;
		do
		begin
			@(posedge MCLK_I);
			if (ARVALID_I && ARREADY_O === 1'b1)
				ARVALID_I <= 1'b0;
		end
		while (RVALID_O !== 1'b1);
		resp = RRESP_O;
		RREADY_I <= 1'b0;
		check({30'h0, resp}, {30'h0, er}, "read response");
		if (er == dac_pkg::RESP_OKAY)
			check(RDATA_O, ed, "read data");
	endtask : axi_read

	// One frame, with the input buffers watched during and after it
	task automatic frame(input logic [31:0] w, input int n);
		fork
			host.send_frame(w, n, rb);
			begin
				#201;
				check({31'h0, INBUF_EN_O}, 32'h1, "buffers on in frame");
			end
		join
		check({31'h0, INBUF_EN_O}, 32'h0, "buffers off after frame");
		@(posedge MCLK_I);
	endtask : frame

	function automatic logic [31:0] word(input logic [1:0] ch, input logic rs, input logic [11:0] c);
		return {16'h0, ch, rs, 1'b0, c};
	endfunction : word

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		axi_read(dac_pkg::STAT_OFS, 32'h0, dac_pkg::RESP_OKAY);
		axi_read(dac_pkg::CTRL_OFS, 32'h0, dac_pkg::RESP_OKAY);
		axi_read(8'hFC, 32'h0, dac_pkg::RESP_SLVERR);
		axi_write(8'hFC, 32'h3, dac_pkg::RESP_SLVERR);
	endtask : t_reset

	// Frame waits in the input register until a load pulse
	task automatic t_pulse_load();
		frame(word(2'h1, 1'b1, 12'hA5C), 16);
		axi_read(8'h24, 32'h2A5C, dac_pkg::RESP_OKAY);
		check({20'h0, DAC_CODE_O[12 +: 12]}, 32'h0, "dac held");
		axi_read(dac_pkg::STAT_OFS, 32'h120, dac_pkg::RESP_OKAY);
		LOAD_OUTPUTS_N_I <= 1'b0;
		wait_clk(8);
		LOAD_OUTPUTS_N_I <= 1'b1;
		wait_clk(4);
		check({20'h0, DAC_CODE_O[12 +: 12]}, 32'hA5C, "dac loaded");
		check({28'h0, REF_BUF_O}, 32'h2, "ref select");
	endtask : t_pulse_load

	// Short and long frames in standalone mode are discarded
	task automatic t_abort();
		frame(word(2'h0, 1'b1, 12'h0FF), 15);
		axi_read(dac_pkg::STAT_OFS, 32'h104, dac_pkg::RESP_OKAY);
		axi_write(dac_pkg::STAT_OFS, 32'h4, dac_pkg::RESP_OKAY);
		frame({15'h0, 1'b1, word(2'h0, 1'b1, 12'hABC)}, 17);
		axi_read(dac_pkg::STAT_OFS, 32'h104, dac_pkg::RESP_OKAY);
		axi_read(dac_pkg::IN_BASE, 32'h0, dac_pkg::RESP_OKAY);
		axi_write(dac_pkg::STAT_OFS, 32'h4, dac_pkg::RESP_OKAY);
		axi_read(dac_pkg::STAT_OFS, 32'h100, dac_pkg::RESP_OKAY);
	endtask : t_abort

	// Load held low passes frames straight through; chain output reads back
	task automatic t_hold_low();
		LOAD_OUTPUTS_N_I <= 1'b0;
		frame(word(2'h2, 1'b0, 12'h123), 16);
		check({16'h0, rb}, word(2'h0, 1'b1, 12'hABC), "chain readback");
		check({20'h0, DAC_CODE_O[24 +: 12]}, 32'h123, "dac direct");
		LOAD_OUTPUTS_N_I <= 1'b1;
		wait_clk(4);
	endtask : t_hold_low

	// Chain mode keeps the last sixteen bits; load through the control register
	task automatic t_chain();
		CHAIN_ENABLE_I <= 1'b1;
		wait_clk(4);
		frame({15'h0, 1'b1, word(2'h3, 1'b1, 12'h7E1)}, 17);
		axi_read(8'h2C, 32'h27E1, dac_pkg::RESP_OKAY);
		axi_read(dac_pkg::STAT_OFS, 32'h382, dac_pkg::RESP_OKAY);
		axi_write(dac_pkg::CTRL_OFS, 32'h1, dac_pkg::RESP_OKAY);
		wait_clk(2);
		check({20'h0, DAC_CODE_O[36 +: 12]}, 32'h7E1, "dac by register");
		check({28'h0, REF_BUF_O}, 32'hA, "ref selects");
		CHAIN_ENABLE_I <= 1'b0;
	endtask : t_chain

	// Zero pin clears the input and DAC registers; power-down pin drives the outputs off
	task automatic t_pins();
		ZERO_ALL_N_I <= 1'b0;
		wait_clk(6);
		ZERO_ALL_N_I <= 1'b1;
		wait_clk(4);
		check(DAC_CODE_O[31:0], 32'h0, "dac cleared");
		check({12'h0, DAC_CODE_O[47:32], REF_BUF_O}, 32'h0, "dac and ref cleared");
		axi_read(8'h2C, 32'h0, dac_pkg::RESP_OKAY);
		POWER_DOWN_N_I <= 1'b0;
		wait_clk(5);
		check({31'h0, PWRDN_O}, 32'h1, "powered down");
		POWER_DOWN_N_I <= 1'b1;
		wait_clk(5);
		check({31'h0, PWRDN_O}, 32'h0, "powered up");
		// Channel zero straight through, then cleared by the control register
		LOAD_OUTPUTS_N_I <= 1'b0;
		frame(word(2'h0, 1'b1, 12'h555), 16);
		LOAD_OUTPUTS_N_I <= 1'b1;
		check({20'h0, DAC_CODE_O[11:0]}, 32'h555, "dac direct ch0");
		check({28'h0, REF_BUF_O}, 32'h1, "ref select ch0");
		axi_write(dac_pkg::CTRL_OFS, 32'h2, dac_pkg::RESP_OKAY);
		wait_clk(2);
		check({20'h0, DAC_CODE_O[11:0]}, 32'h0, "dac cleared by register");
		check({28'h0, REF_BUF_O}, 32'h0, "ref cleared by register");
	endtask : t_pins

	// ==========================================================
	// Main sequence
	initial
	begin
		SRST_I = 1'b1;
		ZERO_ALL_N_I = 1'b1;
		LOAD_OUTPUTS_N_I = 1'b1;
		POWER_DOWN_N_I = 1'b1;
		CHAIN_ENABLE_I = 1'b0;
		AWADDR_I = 8'h00;
		ARADDR_I = 8'h00;
		WDATA_I = 32'h0;
		WSTRB_I = 4'hF;
		AWVALID_I = 1'b0;
		WVALID_I = 1'b0;
		BREADY_I = 1'b0;
		ARVALID_I = 1'b0;
		RREADY_I = 1'b0;
		wait_clk(2);
		SRST_I <= 1'b0;
		wait_clk(4);
		t_reset();
		t_pulse_load();
		t_abort();
		t_hold_low();
		t_chain();
		t_pins();
		finish_test();
	end
endmodule : quad_dac_serial_input_control_tb
